//--- ledcs_ctrl_status.v
// control and status register logic of a two-channel led driver.
// assumes decoded frames on the frm_ ports, converter results and
// pwm timing from the same clock, and raw direct input pins.
`timescale 1ns/1ps
`default_nettype none
`include "ledcs_regs.vh"

module ledcs_ctrl_status #(
    parameter integer WD_CYCLES = `LEDCS_WD_PERIOD_US * `LEDCS_CLK_MHZ,
    parameter integer RESTART_CYCLES = `LEDCS_RESTART_US * `LEDCS_CLK_MHZ,
    parameter integer MINON_LIMIT = `LEDCS_MINON_LIMIT
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        frm_valid,
    input  wire        frm_write,
    input  wire        frm_rc,
    input  wire [5:0]  frm_addr,
    input  wire [23:0] frm_wdata,
    output reg  [23:0] frm_rdata,
    output reg         frm_ack,
    output reg         frm_perr,
    input  wire        din1_pin,
    input  wire        din2_pin,
    input  wire        pwm1_on,
    input  wire        pwm2_on,
    input  wire        pwm1_end,
    input  wire        pwm2_end,
    input  wire        adc1_valid,
    input  wire        adc2_valid,
    input  wire [7:0]  adc1_data,
    input  wire [7:0]  adc2_data,
    input  wire        ton_short1,
    input  wire        ton_short2,
    input  wire        vled1_low,
    input  wire        vled2_low,
    output wire        buck1_en,
    output wire        buck2_en,
    output reg  [6:0]  offtime_vus,
    output reg  [12:0] boost_khz_x10,
    output reg  [5:0]  win1_lo_v,
    output reg  [5:0]  win1_hi_v,
    output reg  [5:0]  win2_lo_v,
    output reg  [5:0]  win2_hi_v,
    output reg         limp_home_mode
);

    // ==========================================================
    // decoders
    function [6:0] offt_dec;
        input [3:0] code;
        begin
            if (!code[3])
                offt_dec = 7'h0a + {3'h0, code[2:0], 1'b0}; // see RULE_04
            else if (!code[2])
                offt_dec = 7'h1c + {3'h0, code[1:0], 2'h0}; // see RULE_04
            else
                offt_dec = 7'h30 + {2'h0, code[1:0], 3'h0}; // see RULE_04
        end
    endfunction

    function [12:0] bst_dec;
        input [2:0] code;
        begin
            case (code) // see RULE_06
                3'h0: bst_dec = 13'h03e8;
                3'h1: bst_dec = 13'h05eb;
                3'h2: bst_dec = 13'h07d0;
                3'h3: bst_dec = 13'h09c4;
                3'h4: bst_dec = 13'h0bd6;
                3'h5: bst_dec = 13'h0df2;
                3'h6: bst_dec = 13'h0fa0;
                default: bst_dec = 13'h11c1;
            endcase
        end
    endfunction

    // low edge in bits 11:6, high edge in bits 5:0
    function [11:0] win_dec;
        input [1:0] code;
        begin
            case (code) // see RULE_07
                2'h0: win_dec = {6'h0a, 6'h19};
                2'h1: win_dec = {6'h19, 6'h28};
                2'h2: win_dec = {6'h28, 6'h32};
                default: win_dec = {6'h32, 6'h3c};
            endcase
        end
    endfunction

    // buck state from map code: off, pwm, on, pin
    function map_on;
        input [1:0] code;
        input       pwm;
        input       pin;
        begin
            case (code) // see RULE_05
                2'h0: map_on = 1'b0;
                2'h1: map_on = pwm;
                2'h2: map_on = 1'b1;
                default: map_on = pin;
            endcase
        end
    endfunction

    // ==========================================================
    // direct pin synchronisers
    reg  [2:0] din1_sync_q;
    reg  [2:0] din2_sync_q;
    reg        din1_q;
    reg        din2_q;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            din1_sync_q <= 3'h0;
            din2_sync_q <= 3'h0;
            din1_q      <= 1'b0;
            din2_q      <= 1'b0;
        end
        else
        begin
            din1_sync_q <= {din1_sync_q[1:0], din1_pin};
            din2_sync_q <= {din2_sync_q[1:0], din2_pin};
            // change accepted once the last two stages agree
            if (din1_sync_q[2] == din1_sync_q[1])
                din1_q <= din1_sync_q[2];
            if (din2_sync_q[2] == din2_sync_q[1])
                din2_q <= din2_sync_q[2];
        end
    end

    // ==========================================================
    // frame decode and parity
    wire par_ok   = ^frm_wdata; // see RULE_03
    wire wr_ok    = frm_valid & frm_write & par_ok;
    wire wr_ctrl3 = wr_ok & (frm_addr == `LEDCS_ADDR_CTRL3);
    wire wr_wd    = wr_ok & (frm_addr == `LEDCS_ADDR_WATCHDOG);
    wire wr_offt  = wr_ok & (frm_addr == `LEDCS_ADDR_OFFTIME);
    wire rc_stat  = frm_valid & ~frm_write & frm_rc &
                    (frm_addr == `LEDCS_ADDR_STATUS1);

    reg  [23:0] ctrl3_q;
    reg  [23:0] wd_reg_q;
    reg  [3:0]  offt_q;
    reg  [7:0]  samp1_q;
    reg  [7:0]  samp2_q;
    reg         short1_q;
    reg         short2_q;
    reg         minon1_q;
    reg         minon2_q;
    reg  [5:0]  cnt1_q;
    reg  [5:0]  cnt2_q;
    reg  [31:0] wd_cnt_q;
    reg  [31:0] rst_cnt_q;

    wire [1:0] map1 = ctrl3_q[`LEDCS_MAP1_HI:`LEDCS_MAP1_LO]; // see RULE_18
    wire [1:0] map2 = ctrl3_q[`LEDCS_MAP2_HI:`LEDCS_MAP2_LO];

    // latched faults hold the buck off
    assign buck1_en = map_on(map1, pwm1_on, din1_q) &
                      ~short1_q & ~minon1_q; // see RULE_13
    assign buck2_en = map_on(map2, pwm2_on, din2_q) &
                      ~short2_q & ~minon2_q; // see RULE_16

    // ==========================================================
    // control registers
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl3_q  <= `LEDCS_CTRL3_RST;
            wd_reg_q <= `LEDCS_WATCHDOG_RST;
            offt_q   <= `LEDCS_OFFTIME_RST;
        end
        else
        begin
            if (wr_ctrl3)
                ctrl3_q <= frm_wdata;
            // reserved bits stored as written; host keeps them zero
            if (wr_wd)
                wd_reg_q <= frm_wdata; // see RULE_02
            if (wr_offt)
                offt_q <= frm_wdata[`LEDCS_OFFT_HI:`LEDCS_OFFT_LO];
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            offtime_vus   <= 7'h0a;
            boost_khz_x10 <= 13'h09c4;
            win1_lo_v     <= 6'h0a;
            win1_hi_v     <= 6'h19;
            win2_lo_v     <= 6'h0a;
            win2_hi_v     <= 6'h19;
        end
        else
        begin
            offtime_vus   <= offt_dec(offt_q);
            boost_khz_x10 <= bst_dec(
                ctrl3_q[`LEDCS_BST_HI:`LEDCS_BST_LO]);
            {win1_lo_v, win1_hi_v} <= win_dec(
                ctrl3_q[`LEDCS_WIN1_HI:`LEDCS_WIN1_LO]);
            {win2_lo_v, win2_hi_v} <= win_dec(
                ctrl3_q[`LEDCS_WIN2_HI:`LEDCS_WIN2_LO]);
        end
    end

    // ==========================================================
    // watchdog and limp-home
    wire wd_kick = wr_wd & (frm_wdata[`LEDCS_WD_TOGGLE_BIT] !=
                   wd_reg_q[`LEDCS_WD_TOGGLE_BIT]); // see RULE_01
    wire restart = limp_home_mode &
                   (rst_cnt_q == RESTART_CYCLES - 1);

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wd_cnt_q       <= 32'h0;
            rst_cnt_q      <= 32'h0;
            limp_home_mode <= 1'b0;
        end
        else
        begin
            if (wd_kick)
            begin
                wd_cnt_q       <= 32'h0;
                limp_home_mode <= 1'b0;
            end
            else if (wd_cnt_q == WD_CYCLES - 1)
                limp_home_mode <= 1'b1; // see RULE_19
            else
                wd_cnt_q <= wd_cnt_q + 32'h1;
            // auto-restart period only runs in limp-home
            if (!limp_home_mode || restart)
                rst_cnt_q <= 32'h0;
            else
                rst_cnt_q <= rst_cnt_q + 32'h1;
        end
    end

    // ==========================================================
    // min on-time counters and fault flags
    wire [5:0] lim6   = MINON_LIMIT[5:0];
    wire       mset1  = ton_short1 & (cnt1_q == lim6) & ~minon1_q;
    wire       mset2  = ton_short2 & (cnt2_q == lim6) & ~minon2_q;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt1_q   <= 6'h0;
            cnt2_q   <= 6'h0;
            minon1_q <= 1'b0;
            minon2_q <= 1'b0;
            short1_q <= 1'b0;
            short2_q <= 1'b0;
        end
        else
        begin
            // counts survive gaps; cleared only with the flag
            if (rc_stat || (restart && minon1_q))
                cnt1_q <= 6'h0;
            else if (ton_short1 && cnt1_q != lim6)
                cnt1_q <= cnt1_q + 6'h1; // see RULE_17
            if (rc_stat)
                cnt2_q <= 6'h0;
            else if (ton_short2 && cnt2_q != lim6)
                cnt2_q <= cnt2_q + 6'h1; // see RULE_17
            // set wins over clear in every flag below
            if (mset1)
                minon1_q <= 1'b1; // see RULE_17
            else if (rc_stat || restart)
                minon1_q <= 1'b0;
            if (mset2)
                minon2_q <= 1'b1; // see RULE_17
            else if (rc_stat)
                minon2_q <= 1'b0;
            if (mset1 && vled1_low)
                short1_q <= 1'b1; // see RULE_12
            else if (rc_stat || restart)
                short1_q <= 1'b0; // see RULE_14
            if (mset2 && vled2_low)
                short2_q <= 1'b1; // see RULE_15
            else if (rc_stat)
                short2_q <= 1'b0;
        end
    end

    // ==========================================================
    // led voltage samples
    wire upd1 = (map1 == 2'h1) ? (pwm1_end & buck1_en) // see RULE_11
                               : (adc1_valid & buck1_en); // see RULE_10
    wire upd2 = (map2 == 2'h1) ? (pwm2_end & buck2_en) // see RULE_11
                               : (adc2_valid & buck2_en); // see RULE_10

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            samp1_q <= `LEDCS_SAMPLE_RST;
            samp2_q <= `LEDCS_SAMPLE_RST;
        end
        else
        begin
            if (upd1)
                samp1_q <= adc1_data; // see RULE_08
            else if (rc_stat)
                samp1_q <= `LEDCS_SAMPLE_RST;
            if (upd2)
                samp2_q <= adc2_data; // see RULE_09
            else if (rc_stat)
                samp2_q <= `LEDCS_SAMPLE_RST;
        end
    end

    // ==========================================================
    // read path; answer one cycle after the frame
    reg [23:0] rd_d;

    always @*
    begin
        rd_d = 24'h0;
        if (frm_addr == `LEDCS_ADDR_CTRL3)
            rd_d = ctrl3_q;
        else if (frm_addr == `LEDCS_ADDR_WATCHDOG)
            rd_d = {wd_reg_q[23:21], 21'h0};
        else if (frm_addr == `LEDCS_ADDR_STATUS1)
            rd_d = {samp1_q, samp2_q, short1_q, short2_q,
                    3'h0, minon1_q, minon2_q, 1'b0};
        else if (frm_addr == `LEDCS_ADDR_OFFTIME)
            rd_d = {19'h0, offt_q, 1'b0};
        rd_d[0] = ~^rd_d[23:1]; // see RULE_03
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            frm_rdata <= 24'h000001;
            frm_ack   <= 1'b0;
            frm_perr  <= 1'b0;
        end
        else
        begin
            frm_ack  <= frm_valid;
            frm_perr <= frm_valid & frm_write & ~par_ok; // see RULE_03
            // pre-clear values captured here, fields clear alongside
            if (frm_valid && !frm_write)
                frm_rdata <= rd_d; // see RULE_20
        end
    end

endmodule // ledcs_ctrl_status
`default_nettype wire

//--- ledcs_regs.vh
// register offsets, field positions, reset values and timing counts
// for the led driver control and status register logic.
// assumes a 250 mhz system clock and a frame decoder outside the block.
//
// Overview of operation
// RULE_01: host toggles watchdog bit 23 of control four within each period
// RULE_02: host writes reserved bits 22 and 21 of control four as zero
// RULE_03: frame bit 0 is odd parity; checked on writes, generated on reads
// RULE_04: off-time code decodes to 10..24, 28..40, 48..72 volt-microseconds
// RULE_05: input map: 00 off, 01 pwm dimming, 10 on, 11 direct pin
// RULE_06: boost clock code selects 100 up to 454.5 khz
// RULE_07: input window code selects 10-25, 25-40, 40-50 or 50-60 volts
// RULE_08: channel one voltage sample sits in status bits 23..16, resets zero
// RULE_09: channel two voltage sample sits in status bits 15..8, resets zero
// RULE_10: pin or register driven channel refreshes its sample while on
// RULE_11: pwm driven channel samples once per period before on-phase ends
// RULE_12: short flag one set when min on-time one rises with low voltage
// RULE_13: short flag one holds buck one off until read-and-clear
// RULE_14: limp-home auto-clears short flag one every auto-restart period
// RULE_15: short flag two set when min on-time two rises with low voltage
// RULE_16: short flag two holds buck two off until read-and-clear
// RULE_17: min on-time flag set after more than 32 short on-time cycles
// RULE_18: channel one map sits at control three bits 15..14, resets 11
// RULE_19: missed watchdog toggle moves the device into limp-home mode
// RULE_20: read-and-clear returns current values, then clears the fields
`ifndef LEDCS_REGS_VH
`define LEDCS_REGS_VH

// ==========================================================
// register offsets
`define LEDCS_ADDR_CTRL3        6'h03
`define LEDCS_ADDR_WATCHDOG     6'h04
`define LEDCS_ADDR_STATUS1      6'h05
`define LEDCS_ADDR_OFFTIME      6'h06

// ==========================================================
// field positions
`define LEDCS_MAP1_HI           15
`define LEDCS_MAP1_LO           14
`define LEDCS_MAP2_HI           13
`define LEDCS_MAP2_LO           12
`define LEDCS_BST_HI            9
`define LEDCS_BST_LO            7
`define LEDCS_WIN1_HI           5
`define LEDCS_WIN1_LO           4
`define LEDCS_WIN2_HI           3
`define LEDCS_WIN2_LO           2
`define LEDCS_WD_TOGGLE_BIT     23
`define LEDCS_WD_RSV_HI         22
`define LEDCS_WD_RSV_LO         21
`define LEDCS_OFFT_HI           4
`define LEDCS_OFFT_LO           1

// ==========================================================
// reset values
`define LEDCS_CTRL3_RST         24'h00cd80
`define LEDCS_WATCHDOG_RST      24'h000000
`define LEDCS_OFFTIME_RST       4'h0
`define LEDCS_SAMPLE_RST        8'h00

// ==========================================================
// timing
`define LEDCS_CLK_MHZ           250
`define LEDCS_WD_PERIOD_US      50000
`define LEDCS_RESTART_US        10000
`define LEDCS_MINON_LIMIT       32

`endif

//--- ledcs_ctrl_status_assertions.sv
// assertions on the ports of the led driver register block.
// assumes one clock, synchronous reset and frames on the frm_ ports.
`timescale 1ns/1ps
`default_nettype none
module ledcs_ctrl_status_assertions #(
    parameter integer WD_CYCLES = 100
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        frm_valid,
    input wire logic        frm_write,
    input wire logic        frm_rc,
    input wire logic [5:0]  frm_addr,
    input wire logic [23:0] frm_wdata,
    input wire logic [23:0] frm_rdata,
    input wire logic        frm_ack,
    input wire logic        frm_perr,
    input wire logic        buck1_en,
    input wire logic        buck2_en,
    input wire logic [6:0]  offtime_vus,
    input wire logic [12:0] boost_khz_x10,
    input wire logic [5:0]  win1_lo_v,
    input wire logic [5:0]  win1_hi_v,
    input wire logic [5:0]  win2_lo_v,
    input wire logic [5:0]  win2_hi_v,
    input wire logic        limp_home_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ====
    // shadow of what was written
    localparam logic [12:0] BST_X10 [8] = '{13'h3e8, 13'h5eb, 13'h7d0,
        13'h9c4, 13'hbd6, 13'hdf2, 13'hfa0, 13'h11c1};
    localparam logic [5:0]  WIN_LO [4] = '{6'h0a, 6'h19, 6'h28, 6'h32};
    localparam logic [5:0]  WIN_HI [4] = '{6'h19, 6'h28, 6'h32, 6'h3c};
    logic        good_wr;
    logic [23:0] c3_q;
    logic [3:0]  offt_q;
    logic        wd_q;
    logic [31:0] wd_cnt_q;
    assign good_wr = frm_valid && frm_write && (^frm_wdata);
    function automatic logic [6:0] offt_f(input logic [3:0] c);
        if (!c[3])
            offt_f = 7'h0a + {2'b00, c, 1'b0};
        else if (!c[2])
            offt_f = 7'h1c + {3'b000, c[1:0], 2'b00};
        else
            offt_f = 7'h30 + {2'b00, c[1:0], 3'b000};
    endfunction
    always @(posedge clk)
        if (sys_rst)
        begin
            c3_q <= 24'h00cd80;
            offt_q <= 4'h0;
            wd_q <= 1'b0;
            wd_cnt_q <= 32'h0;
        end
        else
        begin
            if (good_wr && frm_addr == 6'h03)
                c3_q <= frm_wdata;
            if (good_wr && frm_addr == 6'h06)
                offt_q <= frm_wdata[4:1];
            if (good_wr && frm_addr == 6'h04 && frm_wdata[23] != wd_q)
            begin
                wd_q <= frm_wdata[23];
                wd_cnt_q <= 32'h0;
            end
            else if (wd_cnt_q != 32'hffffffff)
                wd_cnt_q <= wd_cnt_q + 32'h1; // saturates, never wraps
        end
    // ====
    // properties
    property p_perr;
        frm_valid && frm_write && !(^frm_wdata) |=> frm_perr;
    endproperty
    a_perr: assert property (p_perr)
        else $error("no parity error");
    property p_rd_par;
        frm_ack |-> ^frm_rdata;
    endproperty
    a_rd_par: assert property (p_rd_par)
        else $error("bad read parity");
    property p_offt;
        good_wr && frm_addr == 6'h06 |=> ##1 offtime_vus == offt_f(offt_q);
    endproperty
    a_offt: assert property (p_offt)
        else $error("bad off-time");
    property p_bst;
        good_wr && frm_addr == 6'h03 |=> ##1
            boost_khz_x10 == BST_X10[c3_q[9:7]];
    endproperty
    a_bst: assert property (p_bst)
        else $error("bad boost clock");
    property p_win;
        good_wr && frm_addr == 6'h03 |=> ##1
            win1_lo_v == WIN_LO[c3_q[5:4]] &&
            win1_hi_v == WIN_HI[c3_q[5:4]] &&
            win2_lo_v == WIN_LO[c3_q[3:2]] &&
            win2_hi_v == WIN_HI[c3_q[3:2]];
    endproperty
    a_win: assert property (p_win)
        else $error("bad window");
    property p_off1;
        c3_q[15:14] == 2'b00 |-> !buck1_en;
    endproperty
    a_off1: assert property (p_off1)
        else $error("buck one on");
    property p_off2;
        c3_q[13:12] == 2'b00 |-> !buck2_en;
    endproperty
    a_off2: assert property (p_off2)
        else $error("buck two on");
    property p_wd_limp;
        wd_cnt_q > WD_CYCLES + 2 |-> limp_home_mode;
    endproperty
    a_wd_limp: assert property (p_wd_limp)
        else $error("no limp");
    property p_wd_act;
        wd_cnt_q > 2 && wd_cnt_q < WD_CYCLES - 2 |-> !limp_home_mode;
    endproperty
    a_wd_act: assert property (p_wd_act)
        else $error("early limp");
    property p_rst;
        $fell(sys_rst) |-> frm_rdata == 24'h000001 && !limp_home_mode;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad reset");
    c_rc: cover property (frm_valid && frm_rc);
    c_perr: cover property (frm_perr);
    c_limp: cover property ($rose(limp_home_mode));
endmodule // ledcs_ctrl_status_assertions
bind ledcs_ctrl_status ledcs_ctrl_status_assertions #(
    .WD_CYCLES(WD_CYCLES)
) chk_u (
    .clk(clk), .sys_rst(sys_rst), .frm_valid(frm_valid),
    .frm_write(frm_write), .frm_rc(frm_rc), .frm_addr(frm_addr),
    .frm_wdata(frm_wdata), .frm_rdata(frm_rdata), .frm_ack(frm_ack),
    .frm_perr(frm_perr), .buck1_en(buck1_en), .buck2_en(buck2_en),
    .offtime_vus(offtime_vus), .boost_khz_x10(boost_khz_x10),
    .win1_lo_v(win1_lo_v), .win1_hi_v(win1_hi_v), .win2_lo_v(win2_lo_v),
    .win2_hi_v(win2_hi_v), .limp_home_mode(limp_home_mode)
);
`default_nettype wire

//--- ledcs_host_model.sv
// host side: issues register frames and queues the expected answers.
// assumes the bench top module owns the check task.
`timescale 1ns/1ps
`default_nettype none
module ledcs_host_model (
    input  wire logic        clk,
    output var  logic        frm_valid,
    output var  logic        frm_write,
    output var  logic        frm_rc,
    output var  logic [5:0]  frm_addr,
    output var  logic [23:0] frm_wdata,
    input  wire logic [23:0] frm_rdata,
    input  wire logic        frm_ack,
    input  wire logic        frm_perr
);
    // ====
    // frame driver
    logic [25:0] exp_q [$];
    logic [25:0] e;
    initial
    begin
        frm_valid = 1'b0;
        frm_write = 1'b0;
        frm_rc = 1'b0;
        frm_addr = 6'h3f;
        frm_wdata = 24'h5a5a5a;
    end
    task automatic frame(input logic w, input logic rc, input logic bad,
        input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        frm_valid <= 1'b1;
        frm_write <= w;
        frm_rc <= rc;
        frm_addr <= a;
        frm_wdata <= {d[23:1], ~^d[23:1] ^ bad};
        exp_q.push_back({!w, w & bad, d[23:1], ~^d[23:1]});
        @(posedge clk);
        frm_valid <= 1'b0;
        frm_addr <= ~a; // released lines must not hold their value
        frm_wdata <= ~frm_wdata;
    endtask
    always @(posedge clk)
        if (frm_ack === 1'b1)
        begin
            e = exp_q.pop_front();
            tb_led_driver_ctrl_status_regs.check(
                "perr", {23'h0, frm_perr}, {23'h0, e[24]});
            if (e[25])
                tb_led_driver_ctrl_status_regs.check(
                    "rdata", frm_rdata, e[23:0]);
        end
endmodule // ledcs_host_model
`default_nettype wire

//--- tb_led_driver_ctrl_status_regs.sv
// self-checking bench for the led driver register block.
// assumes the host model drives frames and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_led_driver_ctrl_status_regs;
    // ====
    // signals
    localparam integer WD = 300;
    localparam integer RS = 40;
    logic clk = 1'b0, sys_rst = 1'b1, wd_bit = 1'b0;
    logic din1_pin = 1'b1, din2_pin = 1'b0, pwm1_on = 1'b0, pwm2_on = 1'b1;
    logic pwm1_end = 1'b0, pwm2_end = 1'b0, adc1_valid = 1'b0;
    logic adc2_valid = 1'b0, ton_short1 = 1'b0, ton_short2 = 1'b0;
    logic vled1_low = 1'b0, vled2_low = 1'b0;
    logic [7:0] adc1_data = 8'h00, adc2_data = 8'h00, d1, d2;
    logic frm_valid, frm_write, frm_rc, frm_ack, frm_perr;
    logic buck1_en, buck2_en, limp_home_mode;
    logic [5:0] frm_addr;
    logic [23:0] frm_wdata, frm_rdata;
    int bad_count = 0, cmp_count = 0, cyc_count = 0;
    always #2 clk = ~clk;
    ledcs_host_model host_u (.clk(clk), .frm_valid(frm_valid),
        .frm_write(frm_write), .frm_rc(frm_rc), .frm_addr(frm_addr),
        .frm_wdata(frm_wdata), .frm_rdata(frm_rdata), .frm_ack(frm_ack),
        .frm_perr(frm_perr));
    ledcs_ctrl_status #(.WD_CYCLES(WD), .RESTART_CYCLES(RS),
        .MINON_LIMIT(32)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .frm_valid(frm_valid), .frm_write(frm_write), .frm_rc(frm_rc),
        .frm_addr(frm_addr), .frm_wdata(frm_wdata), .frm_rdata(frm_rdata),
        .frm_ack(frm_ack), .frm_perr(frm_perr), .din1_pin(din1_pin),
        .din2_pin(din2_pin), .pwm1_on(pwm1_on), .pwm2_on(pwm2_on),
        .pwm1_end(pwm1_end), .pwm2_end(pwm2_end), .adc1_valid(adc1_valid),
        .adc2_valid(adc2_valid), .adc1_data(adc1_data),
        .adc2_data(adc2_data), .ton_short1(ton_short1),
        .ton_short2(ton_short2), .vled1_low(vled1_low),
        .vled2_low(vled2_low), .buck1_en(buck1_en), .buck2_en(buck2_en),
        .offtime_vus(), .boost_khz_x10(), .win1_lo_v(), .win1_hi_v(),
        .win2_lo_v(), .win2_hi_v(), .limp_home_mode(limp_home_mode));
    // ====
    // tasks
    task automatic check(input string name, input logic [23:0] seen,
        input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        host_u.frame(1'b1, 1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [23:0] d);
        host_u.frame(1'b0, 1'b0, 1'b0, a, d);
    endtask
    task automatic ben(input logic e1, input logic e2);
        check("buck1_en", {23'h0, buck1_en}, {23'h0, e1});
        check("buck2_en", {23'h0, buck2_en}, {23'h0, e2});
    endtask
    task automatic kick();
        wd_bit = ~wd_bit;
        wr(6'h04, {wd_bit, 23'h0});
    endtask
    function automatic logic [23:0] c3(input logic [1:0] m1, m2,
        input logic [2:0] b, input logic [1:0] w);
        c3 = {8'h00, m1, m2, 2'b11, b, 1'b0, w, w, 2'b00};
    endfunction
    task automatic minon(input logic p1, input logic p2);
        for (int k = 1; k <= 33; k++)
        begin
            if (k == 33)
                #1 ben(1'b1, 1'b1);
            @(posedge clk);
            ton_short1 <= p1;
            ton_short2 <= p2;
            @(posedge clk);
            ton_short1 <= 1'b0;
            ton_short2 <= 1'b0;
        end
        #1 ben(!p1, !p2);
    endtask
    // ====
    // sequence; watchdog kicked per scenario, a missed kick means limp
    always @(posedge clk)
    begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 6000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(15420));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(6'h03, 24'h00cd80);
        rd(6'h05, 24'h000000);
        rd(6'h04, 24'h000000);
        kick();
        for (int i = 0; i < 16; i++)
        begin
            wr(6'h06, {19'h0, i[3:0], 1'b0});
            wr(6'h03, c3(2'b10, 2'b01, i[2:0], i[1:0]));
            rd(6'h03, c3(2'b10, 2'b01, i[2:0], i[1:0]));
        end
        host_u.frame(1'b1, 1'b0, 1'b1, 6'h03, 24'h0);
        rd(6'h03, c3(2'b10, 2'b01, 3'h7, 2'h3));
        kick();
        for (int m = 0; m < 4; m++)
        begin
            wr(6'h03, c3(m[1:0], m[1:0], 3'h3, 2'h0));
            #1 ben(m[1], m == 1 || m == 2);
        end
        wr(6'h03, c3(2'b10, 2'b01, 3'h3, 2'h0));
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        @(posedge clk);
        adc1_data <= d1;
        adc2_data <= ~d2;
        adc1_valid <= 1'b1;
        adc2_valid <= 1'b1;
        @(posedge clk);
        adc1_valid <= 1'b0;
        adc2_valid <= 1'b0;
        adc2_data <= d2;
        pwm2_end <= 1'b1;
        @(posedge clk);
        pwm2_end <= 1'b0;
        host_u.frame(1'b0, 1'b1, 1'b0, 6'h05,
            {d1, d2, 8'h00});
        rd(6'h05, 24'h0);
        for (int j = 0; j < 2; j++)
        begin
            kick();
            vled1_low <= (j == 0);
            vled2_low <= (j == 1);
            minon(1'b1, 1'b1);
            host_u.frame(1'b0, 1'b1, 1'b0, 6'h05,
                {16'h0, j == 0, j == 1, 6'h06});
            @(posedge clk);
            #1 ben(1'b1, 1'b1);
        end
        kick();
        vled1_low <= 1'b1;
        minon(1'b1, 1'b0);
        repeat (WD + RS + 20) @(posedge clk);
        #1 check("limp", {23'h0, limp_home_mode}, 24'h1);
        ben(1'b1, 1'b1);
        rd(6'h05, 24'h0);
        kick();
        #1 check("limp", {23'h0, limp_home_mode}, 24'h0);
        print_verdict();
    end
endmodule // tb_led_driver_ctrl_status_regs
`default_nettype wire
